// >>> rtl/dite_pkg.sv
package dite_pkg;
  localparam int DITE_NLINES = 4;
  localparam int DITE_NPFI = 16;
  localparam int DITE_NEXT = 8;
  localparam int DITE_FIFO_DEPTH = 16;
  localparam int DITE_FIFO_AW = 4;

  // register byte addresses (word index = address / 4)
  localparam logic [7:0] DITE_REG_CTRL = 8'h00;
  localparam logic [7:0] DITE_REG_CFG = 8'h04;
  localparam logic [7:0] DITE_REG_DIV = 8'h08;
  localparam logic [7:0] DITE_REG_DELAY = 8'h0c;
  localparam logic [7:0] DITE_REG_COUNT = 8'h10;
  localparam logic [7:0] DITE_REG_PRETRIG = 8'h14;
  localparam logic [7:0] DITE_REG_LINES = 8'h18;
  localparam logic [7:0] DITE_REG_PFI = 8'h1c;
  localparam logic [7:0] DITE_REG_STATUS = 8'h20;
  localparam logic [7:0] DITE_REG_STATIC = 8'h24;

  // ctrl bits (write-one actions)
  localparam int DITE_CTRL_START = 0;
  localparam int DITE_CTRL_STOP = 1;
  localparam int DITE_CTRL_CLR_OVF = 2;

  // cfg fields
  localparam int DITE_CFG_TB_LSB = 0;     // 3 bits timebase select
  localparam int DITE_CFG_TBEDGE = 3;     // 1 = falling
  localparam int DITE_CFG_EXTCLK = 4;     // external strobe
  localparam int DITE_CFG_CLKEDGE = 5;    // strobe edge, 1 = falling
  localparam int DITE_CFG_FINITE = 6;
  localparam int DITE_CFG_RETRIG = 7;
  localparam int DITE_CFG_HWTRIG = 8;
  localparam int DITE_CFG_TRGEDGE = 9;    // 1 = falling
  localparam int DITE_CFG_REFEN = 10;
  localparam int DITE_CFG_REFEDGE = 11;
  localparam int DITE_CFG_PAUSEEN = 12;
  localparam int DITE_CFG_PAUSELVL = 13;  // 1 = pause while high
  localparam int DITE_CFG_STRIG_LSB = 16; // 3-bit ext line select
  localparam int DITE_CFG_SCLK_LSB = 19;
  localparam int DITE_CFG_REF_LSB = 22;
  localparam int DITE_CFG_PAUSE_LSB = 25;
  localparam int DITE_CFG_TBX_LSB = 28;
  localparam int DITE_SEL_W = 3;

  typedef enum logic [2:0] {
    DITE_TB_100M, DITE_TB_20M, DITE_TB_100K, DITE_TB_BP10M, DITE_TB_EXT
  } dite_tb_t;

  localparam logic [31:0] DITE_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DITE_DIV_RST = 32'h0000_0001;
  localparam logic [31:0] DITE_DELAY_RST = 32'h0000_0002;
  localparam logic [31:0] DITE_COUNT_RST = 32'h0000_0004;

  // line modes, 2 bits per line
  localparam logic [1:0] DITE_LINE_STATIC = 2'h0;
  localparam logic [1:0] DITE_LINE_OUT = 2'h1;
  localparam logic [1:0] DITE_LINE_WAVE = 2'h2;

  // pfi route codes, 2 bits per pin
  localparam logic [1:0] DITE_PFI_IN = 2'h0;
  localparam logic [1:0] DITE_PFI_STROBE = 2'h1;
  localparam logic [1:0] DITE_PFI_STRIG = 2'h2;
endpackage

// >>> rtl/dite_engine.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - each selected strobe edge stores the waveform-mode input lines in the fifo, other lines as zero
// - strobe arriving with fifo full sets a sticky overflow flag
// - strobes are ignored when no acquisition runs
// - strobes are ignored while the pause trigger is active
// - strobe is internal unless an external source is configured
// - start trigger starts engine; finite run stops by hardware or software
// - start-to-run delay in timebase ticks, default two; the divider only starts counting after it
// - timebase chosen from 100M, 20M, 100k, backplane 10M or lines
// - programmable divider on timebase forms the internal strobe
// - timebase edge selectable except for 100M and 20M sources
// - the timebase never reaches any connector pin
// - strobe routed to a function pin is driven inverted
// - finite ends on count, reached after the reference trigger when enabled; continuous on stop
// - retriggerable finite runs a full burst per start pulse
// - start triggers ignored during a burst; then wait for next
// - the reference trigger is never retriggerable
// - start trigger source and edge are selectable
// - start trigger routed out is an active-high pulse
// - all function pins are inputs after reset
// - each line is output, static input or waveform input
// - dma port drains the fifo toward host memory
// - start trigger also begins pretriggered acquisitions
// - pause acts on level, polarity programmable
// - reference trigger armed only after pretrigger samples captured
module dite_engine
  import dite_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic tb_100m_i,
  input wire logic tb_20m_i,
  input wire logic tb_100k_i,
  input wire logic tb_bp10m_i,
  input wire logic [DITE_NEXT-1:0] board_sync_bus_line_i,
  input wire logic [DITE_NLINES-1:0] parallel_input_lines_i,
  output logic [DITE_NLINES-1:0] parallel_lines_o,
  output logic [DITE_NLINES-1:0] parallel_lines_oe_o,
  input wire logic [DITE_NPFI-1:0] programmable_function_pin_i,
  output logic [DITE_NPFI-1:0] programmable_function_pin_o,
  output logic [DITE_NPFI-1:0] programmable_function_pin_oe_o,
  output logic [DITE_NLINES-1:0] dma_data_o,
  output logic dma_valid_o,
  input wire logic dma_ready_i,
  output logic running_o
);
  typedef enum logic [2:0] {
    DITE_IDLE, DITE_ARM, DITE_DELAY, DITE_RUN, DITE_WAITTRIG
  } dite_st_t;

  typedef struct packed {
    logic [1:0] [DITE_NEXT-1:0] ext_s;
    logic [1:0] [3:0] tb_s;
    logic [1:0] [DITE_NLINES-1:0] lin_s;
    logic [1:0] [DITE_NPFI-1:0] pfi_s;
    logic tb_prev;
    logic sclk_prev;
    logic strg_prev;
    logic ref_prev;
    dite_st_t st;
    logic [31:0] cfg;
    logic [31:0] div;
    logic [31:0] dly;
    logic [31:0] cnt_set;
    logic [31:0] pre_set;
    logic [31:0] lines_cfg;
    logic [31:0] pfi_cfg;
    logic [DITE_NLINES-1:0] static_out;
    logic [31:0] div_cnt;
    logic [31:0] dly_cnt;
    logic [31:0] smp_cnt;
    logic ref_armed;
    logic ref_seen;
    logic ovf;
    logic strobe_q;
    logic strig_pulse;
    logic [DITE_NLINES-1:0] [DITE_FIFO_DEPTH-1:0] mem;
    logic [DITE_FIFO_AW:0] wp;
    logic [DITE_FIFO_AW:0] rp;
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic [DITE_NLINES-1:0] lines_o;
    logic [DITE_NLINES-1:0] lines_oe;
    logic [DITE_NPFI-1:0] pfi_o;
    logic [DITE_NPFI-1:0] pfi_oe;
    logic [DITE_NLINES-1:0] dma_d;
    logic dma_v;
    logic run_o;
  } dite_state_t;

  dite_state_t s_r, s_nxt;

  logic [DITE_NEXT-1:0] ext;
  logic [DITE_NLINES-1:0] wave_mask;
  logic [DITE_NLINES-1:0] static_mask;
  logic [DITE_NLINES-1:0] out_mask;
  logic [DITE_NPFI-1:0] strobe_route;
  logic [DITE_NPFI-1:0] strig_route;
  logic [DITE_NPFI-1:0] pfi_in_route;

  // per-line and per-pin decode of the mode fields
  genvar gi;
  generate
    for (gi = 0; gi < DITE_NLINES; gi++) begin : g_line
      assign wave_mask[gi] = s_r.lines_cfg[2*gi +: 2] == DITE_LINE_WAVE;
      assign static_mask[gi] = s_r.lines_cfg[2*gi +: 2] == DITE_LINE_STATIC;
      assign out_mask[gi] = s_r.lines_cfg[2*gi +: 2] == DITE_LINE_OUT;
    end
    for (gi = 0; gi < DITE_NPFI; gi++) begin : g_pfi
      assign strobe_route[gi] = s_r.pfi_cfg[2*gi +: 2] == DITE_PFI_STROBE;
      assign strig_route[gi] = s_r.pfi_cfg[2*gi +: 2] == DITE_PFI_STRIG;
      assign pfi_in_route[gi] = s_r.pfi_cfg[2*gi +: 2] == DITE_PFI_IN;
    end
  endgenerate

  // low pfi pins and sync bus lines share the external select space
  assign ext = s_r.ext_s[1] | s_r.pfi_s[1][DITE_NEXT-1:0];

  always_comb begin
    logic tb_lvl, tb_edge, tb_rise, tb_fall, tb_tick;
    logic int_strobe, sclk_lvl, sclk_edge, strobe;
    logic strg_lvl, strg_edge, ref_lvl, ref_edge, pause;
    logic start_evt, finite, hit, fifo_full, fifo_empty, acc;
    logic [DITE_SEL_W-1:0] tbsel;
    logic [DITE_FIFO_AW-1:0] widx;
    logic [7:0] a;
    tb_lvl = 1'b0;
    tb_edge = 1'b0;
    tb_rise = 1'b0;
    tb_fall = 1'b0;
    tb_tick = 1'b0;
    int_strobe = 1'b0;
    sclk_lvl = 1'b0;
    sclk_edge = 1'b0;
    strobe = 1'b0;
    strg_lvl = 1'b0;
    strg_edge = 1'b0;
    ref_lvl = 1'b0;
    ref_edge = 1'b0;
    pause = 1'b0;
    start_evt = 1'b0;
    hit = 1'b0;
    widx = '0;
    a = 8'h00;
    finite = 1'b0;
    tbsel = '0;
    fifo_full = 1'b0;
    fifo_empty = 1'b0;
    acc = 1'b0;
    s_nxt = s_r;
    finite = s_r.cfg[DITE_CFG_FINITE];
    tbsel = s_r.cfg[DITE_CFG_TB_LSB +: DITE_SEL_W];

    s_nxt.ext_s = {s_r.ext_s[0], board_sync_bus_line_i};
    s_nxt.tb_s = {s_r.tb_s[0], {tb_bp10m_i, tb_100k_i, tb_20m_i, tb_100m_i}};
    s_nxt.lin_s = {s_r.lin_s[0], parallel_input_lines_i};
    s_nxt.pfi_s = {s_r.pfi_s[0], programmable_function_pin_i};

    // timebase mux and edge
    unique case (tbsel)
      DITE_TB_100M: tb_lvl = s_r.tb_s[1][0];
      DITE_TB_20M: tb_lvl = s_r.tb_s[1][1];
      DITE_TB_100K: tb_lvl = s_r.tb_s[1][2];
      DITE_TB_BP10M: tb_lvl = s_r.tb_s[1][3];
      default: tb_lvl = ext[s_r.cfg[DITE_CFG_TBX_LSB +: DITE_SEL_W]];
    endcase
    s_nxt.tb_prev = tb_lvl;
    tb_rise = tb_lvl & ~s_r.tb_prev;
    tb_fall = ~tb_lvl & s_r.tb_prev;
    // fast timebases are sampled far below their rate here; only rise used
    tb_edge = (tbsel == DITE_TB_100M || tbsel == DITE_TB_20M) ? tb_rise :
              (s_r.cfg[DITE_CFG_TBEDGE] ? tb_fall : tb_rise);
    tb_tick = tb_edge;

    sclk_lvl = ext[s_r.cfg[DITE_CFG_SCLK_LSB +: DITE_SEL_W]];
    s_nxt.sclk_prev = sclk_lvl;
    sclk_edge = s_r.cfg[DITE_CFG_CLKEDGE] ? (~sclk_lvl & s_r.sclk_prev) :
                (sclk_lvl & ~s_r.sclk_prev);
    strg_lvl = ext[s_r.cfg[DITE_CFG_STRIG_LSB +: DITE_SEL_W]];
    s_nxt.strg_prev = strg_lvl;
    strg_edge = s_r.cfg[DITE_CFG_TRGEDGE] ? (~strg_lvl & s_r.strg_prev) :
                (strg_lvl & ~s_r.strg_prev);
    ref_lvl = ext[s_r.cfg[DITE_CFG_REF_LSB +: DITE_SEL_W]];
    s_nxt.ref_prev = ref_lvl;
    ref_edge = s_r.cfg[DITE_CFG_REFEDGE] ? (~ref_lvl & s_r.ref_prev) :
               (ref_lvl & ~s_r.ref_prev);
    pause = s_r.cfg[DITE_CFG_PAUSEEN] &
            (ext[s_r.cfg[DITE_CFG_PAUSE_LSB +: DITE_SEL_W]] ==
             s_r.cfg[DITE_CFG_PAUSELVL]);

    // divider on the timebase
    if (s_r.st == DITE_RUN && tb_tick) begin
      if (s_r.div_cnt + 32'h1 >= s_r.div) begin
        s_nxt.div_cnt = '0;
        int_strobe = 1'b1;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 32'h1;
      end
    end
    strobe = s_r.cfg[DITE_CFG_EXTCLK] ? sclk_edge : int_strobe;

    fifo_full = (s_r.wp[DITE_FIFO_AW] != s_r.rp[DITE_FIFO_AW]) &&
                (s_r.wp[DITE_FIFO_AW-1:0] == s_r.rp[DITE_FIFO_AW-1:0]);
    fifo_empty = s_r.wp == s_r.rp;

    // ignored outside a run and while paused
    hit = strobe && s_r.st == DITE_RUN && !pause;
    s_nxt.strobe_q = hit;

    // hardware start trigger edge; software start enters via the ctrl register
    s_nxt.strig_pulse = 1'b0;
    if (s_r.cfg[DITE_CFG_HWTRIG] && strg_edge) begin
      start_evt = 1'b1;
    end

    // dma drain
    if (s_r.dma_v && dma_ready_i) begin
      s_nxt.dma_v = 1'b0;
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (!s_nxt.dma_v && s_nxt.rp != s_r.wp) begin
      s_nxt.dma_v = 1'b1;
      for (int i = 0; i < DITE_NLINES; i++) begin
        s_nxt.dma_d[i] = s_r.mem[i][s_nxt.rp[DITE_FIFO_AW-1:0]];
      end
    end

    if (hit) begin
      if (fifo_full) begin
        s_nxt.ovf = 1'b1;
      end else begin
        widx = s_r.wp[DITE_FIFO_AW-1:0];
        for (int i = 0; i < DITE_NLINES; i++) begin
          s_nxt.mem[i][widx] = s_r.lin_s[1][i] & wave_mask[i];
        end
        s_nxt.wp = s_r.wp + 1'b1;
      end
      s_nxt.smp_cnt = s_r.smp_cnt + 32'h1;
      if (s_r.smp_cnt + 32'h1 >= s_r.pre_set) begin
        s_nxt.ref_armed = 1'b1;
      end
    end

    if (s_r.cfg[DITE_CFG_REFEN] && s_r.ref_armed && ref_edge &&
        !s_r.ref_seen && s_r.st == DITE_RUN) begin
      // posttrigger samples follow; no second reference accepted
      s_nxt.ref_seen = 1'b1;
      s_nxt.smp_cnt = s_r.pre_set;
    end

    unique case (s_r.st)
      DITE_IDLE: ;
      DITE_ARM, DITE_WAITTRIG: begin
        if (start_evt || !s_r.cfg[DITE_CFG_HWTRIG]) begin
          s_nxt.st = DITE_DELAY;
          s_nxt.dly_cnt = '0;
          s_nxt.strig_pulse = 1'b1;
        end
      end
      DITE_DELAY: begin
        if (tb_tick) begin
          s_nxt.dly_cnt = s_r.dly_cnt + 32'h1;
          if (s_r.dly_cnt + 32'h1 >= s_r.dly) begin
            s_nxt.st = DITE_RUN;
            s_nxt.div_cnt = '0;
          end
        end
      end
      DITE_RUN: begin
        // triggers during a burst fall through unused
        if (finite && ((s_nxt.smp_cnt >= s_r.cnt_set && !s_r.cfg[DITE_CFG_REFEN])
            || (s_r.ref_seen && s_nxt.smp_cnt >= s_r.cnt_set))) begin
          s_nxt.smp_cnt = '0;
          s_nxt.ref_armed = 1'b0;
          s_nxt.ref_seen = 1'b0;
          s_nxt.st = s_r.cfg[DITE_CFG_RETRIG] ? DITE_WAITTRIG : DITE_IDLE;
        end
      end
      default: s_nxt.st = DITE_IDLE;
    endcase
    if (s_r.st == DITE_WAITTRIG && !s_r.cfg[DITE_CFG_HWTRIG]) begin
      s_nxt.st = DITE_IDLE;
    end

    // wishbone slave, one wait state
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    acc = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
    a = wb_adr_i[7:0];
    if (acc) begin
      s_nxt.rdat = '0;
      s_nxt.ack = 1'b1;
      unique case (a)
        DITE_REG_CTRL: ;
        DITE_REG_CFG: s_nxt.rdat = s_r.cfg;
        DITE_REG_DIV: s_nxt.rdat = s_r.div;
        DITE_REG_DELAY: s_nxt.rdat = s_r.dly;
        DITE_REG_COUNT: s_nxt.rdat = s_r.cnt_set;
        DITE_REG_PRETRIG: s_nxt.rdat = s_r.pre_set;
        DITE_REG_LINES: s_nxt.rdat = s_r.lines_cfg;
        DITE_REG_PFI: s_nxt.rdat = s_r.pfi_cfg;
        DITE_REG_STATUS: s_nxt.rdat = {s_r.smp_cnt[15:0], 8'h00,
            s_r.ref_armed, fifo_full, fifo_empty, s_r.ovf,
            1'b0, s_r.st};
        DITE_REG_STATIC: s_nxt.rdat = {24'h000000,
            s_r.lin_s[1] & static_mask, s_r.static_out};
        default: begin
          s_nxt.ack = 1'b0;
          s_nxt.err = 1'b1;
        end
      endcase
      if (wb_we_i && s_nxt.ack && wb_sel_i[0]) begin
        unique case (a)
          DITE_REG_CTRL: begin
            if (wb_dat_i[DITE_CTRL_START] && s_r.st == DITE_IDLE) begin
              s_nxt.st = DITE_ARM;
              s_nxt.smp_cnt = '0;
            end
            if (wb_dat_i[DITE_CTRL_STOP]) begin
              s_nxt.st = DITE_IDLE;
              s_nxt.smp_cnt = '0;
              s_nxt.ref_armed = 1'b0;
              s_nxt.ref_seen = 1'b0;
            end
            // a new overflow in this cycle outranks the clear
            if (wb_dat_i[DITE_CTRL_CLR_OVF] && !(hit && fifo_full)) begin
              s_nxt.ovf = 1'b0;
            end
          end
          DITE_REG_CFG: s_nxt.cfg = wb_dat_i;
          DITE_REG_DIV: s_nxt.div = wb_dat_i;
          DITE_REG_DELAY: s_nxt.dly = wb_dat_i;
          DITE_REG_COUNT: s_nxt.cnt_set = wb_dat_i;
          DITE_REG_PRETRIG: s_nxt.pre_set = wb_dat_i;
          DITE_REG_LINES: s_nxt.lines_cfg = wb_dat_i;
          DITE_REG_PFI: s_nxt.pfi_cfg = wb_dat_i;
          DITE_REG_STATIC: s_nxt.static_out = wb_dat_i[DITE_NLINES-1:0];
          default: ;
        endcase
      end
    end

    // pin drivers; the timebase has no route here
    s_nxt.lines_o = s_r.static_out & out_mask;
    s_nxt.lines_oe = out_mask;
    s_nxt.pfi_oe = ~pfi_in_route;
    s_nxt.pfi_o = ({DITE_NPFI{~s_r.strobe_q}} & strobe_route) |
                  ({DITE_NPFI{s_r.strig_pulse}} & strig_route);
    s_nxt.run_o = s_r.st != DITE_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.st <= DITE_IDLE;
      s_r.cfg <= DITE_CFG_RST;
      s_r.div <= DITE_DIV_RST;
      s_r.dly <= DITE_DELAY_RST;
      s_r.cnt_set <= DITE_COUNT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign wb_err_o = s_r.err;
  assign parallel_lines_o = s_r.lines_o;
  assign parallel_lines_oe_o = s_r.lines_oe;
  assign programmable_function_pin_o = s_r.pfi_o;
  assign programmable_function_pin_oe_o = s_r.pfi_oe;
  assign dma_data_o = s_r.dma_d;
  assign dma_valid_o = s_r.dma_v;
  assign running_o = s_r.run_o;
endmodule

// >>> sim/dite_engine_chk.sv
`timescale 1ns/100ps
module dite_engine_chk
  import dite_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [DITE_NLINES-1:0] dma_data_o,
  input wire logic dma_valid_o,
  input wire logic dma_ready_i,
  input wire logic running_o,
  input wire logic [DITE_NPFI-1:0] programmable_function_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_answer_next: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o) |=>
    (wb_ack_o || wb_err_o))
    else $error("bus request not answered in the next cycle");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_answer_cause: assert property (
    ($rose(wb_ack_o) || $rose(wb_err_o)) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without a request");
  a_dma_word_hold: assert property (
    (dma_valid_o && !dma_ready_i) |=> (dma_valid_o && $stable(dma_data_o)))
    else $error("dma word dropped or changed before it was taken");
  a_pfi_input_rst: assert property (
    $fell(sys_rst_i) |-> (programmable_function_pin_oe_o == '0))
    else $error("function pin driven after reset");
  a_idle_after_rst: assert property (
    $fell(sys_rst_i) |-> (!running_o && !dma_valid_o))
    else $error("engine active after reset");
  a_run_needs_cmd: assert property (
    $rose(running_o) |->
    ($past(wb_cyc_i) || $past(wb_cyc_i, 2) || $past(wb_cyc_i, 3)))
    else $error("engine started without a start command");
endmodule

// >>> sim/dite_dma_sink.sv
`timescale 1ns/100ps
// far side of the dma port; stall lets the fifo fill to test overflow
module dite_dma_sink
  import dite_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic [DITE_NLINES-1:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic [7:0] count_o,
  output logic [DITE_NLINES-1:0] last_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      count_o <= 8'h00;
      last_o <= '0;
    end else begin
      ready_o <= !stall_i;
      if (valid_i && ready_o) begin
        count_o <= count_o + 8'h01;
        last_o <= data_i;
      end
    end
  end
endmodule

// >>> sim/digital_input_timing_engine_test.sv
`timescale 1ns/100ps
module digital_input_timing_engine_test;
  import dite_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic tb_100k_i = 1'b0;
  logic [7:0] sync_i = 8'h00;
  logic [3:0] lines_i = 4'h0;
  logic [3:0] lines_o, lines_oe, dma_data, snk_last;
  logic [15:0] pfi_o, pfi_oe;
  logic dma_valid, dma_ready, running;
  logic stall = 1'b1;
  logic [7:0] snk_cnt;
  logic [31:0] rv;
  logic re;
  int err_count = 0;
  int tests_run = 0;
  int n;
  logic [7:0] ra [4] = '{DITE_REG_CFG, DITE_REG_DIV, DITE_REG_DELAY,
                         DITE_REG_COUNT};
  logic [31:0] rr [4] = '{DITE_CFG_RST, DITE_DIV_RST, DITE_DELAY_RST,
                          DITE_COUNT_RST};

  always #50 clk_i = ~clk_i;

  dite_engine i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .tb_100m_i(1'b0), .tb_20m_i(1'b0), .tb_100k_i(tb_100k_i),
    .tb_bp10m_i(1'b0), .board_sync_bus_line_i(sync_i),
    .parallel_input_lines_i(lines_i), .parallel_lines_o(lines_o),
    .parallel_lines_oe_o(lines_oe), .programmable_function_pin_i(16'h0),
    .programmable_function_pin_o(pfi_o),
    .programmable_function_pin_oe_o(pfi_oe), .dma_data_o(dma_data),
    .dma_valid_o(dma_valid), .dma_ready_i(dma_ready), .running_o(running));

  dite_dma_sink i_sink (.clk_i(clk_i), .rst_i(sys_rst_i), .stall_i(stall),
    .data_i(dma_data), .valid_i(dma_valid), .ready_o(dma_ready),
    .count_o(snk_cnt), .last_o(snk_last));

  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // answer is taken at the rising edge that samples it; request holds till then
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    bit hit;
    hit = 0;
    @(posedge clk_i);
    wb_adr_i <= {24'h0, a};
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (int i = 0; i < 20 && !hit; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
        hit = 1;
        rv = wb_dat_o;
        re = wb_err_o;
      end
    end
    if (!hit) begin
      err_count++;
      tally_and_finish();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // slow timebase edges: four clocks high, five low, so the 2ff sync sees them
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_i);
      tb_100k_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      tb_100k_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  task automatic drain(input int k);
    stall <= 1'b0;
    for (int i = 0; i < 300 && snk_cnt < k; i++) @(posedge clk_i);
    repeat (6) @(posedge clk_i);
    chk("words drained", k, {24'h0, snk_cnt});
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wb(ra[i], 1'b0, 32'h0);
      chk("reset value", rr[i], rv);
    end
    chk("pfi oe after reset", 32'h0, {16'h0, pfi_oe});
    wb(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, re});
    tick(6);
    wb(DITE_REG_STATUS, 1'b0, 32'h0);
    chk("idle fifo empty", 32'h1, {31'h0, rv[5]});
    lines_i <= 4'ha;
    wb(DITE_REG_LINES, 1'b1, 32'haa);
    wb(DITE_REG_CFG, 1'b1, 32'h42);
    wb(DITE_REG_CTRL, 1'b1, 32'h1);
    tick(30);
    chk("finite run stopped", 32'h0, {31'h0, running});
    drain(4);
    chk("sample value", 32'ha, {28'h0, snk_last});
    stall <= 1'b1;
    wb(DITE_REG_CFG, 1'b1, 32'h2);
    wb(DITE_REG_CTRL, 1'b1, 32'h1);
    tick(24);
    chk("continuous runs on", 32'h1, {31'h0, running});
    wb(DITE_REG_CTRL, 1'b1, 32'h2);
    wb(DITE_REG_STATUS, 1'b0, 32'h0);
    chk("overflow flag", 32'h1, {31'h0, rv[4]});
    chk("fifo full", 32'h1, {31'h0, rv[6]});
    chk("stopped by command", 32'h0, {31'h0, running});
    wb(DITE_REG_CTRL, 1'b1, 32'h4);
    wb(DITE_REG_STATUS, 1'b0, 32'h0);
    chk("overflow cleared", 32'h0, {31'h0, rv[4]});
    drain(20);
    sync_i <= 8'h01;
    wb(DITE_REG_CFG, 1'b1, 32'h3042);
    wb(DITE_REG_CTRL, 1'b1, 32'h1);
    tick(30);
    wb(DITE_REG_STATUS, 1'b0, 32'h0);
    chk("paused run stores none", 32'h1, {31'h0, rv[5]});
    chk("paused run waits", 32'h1, {31'h0, running});
    sync_i <= 8'h00;
    wb(DITE_REG_CTRL, 1'b1, 32'h1);
    tick(30);
    drain(24);
    wb(DITE_REG_CFG, 1'b1, 32'h101c2);
    wb(DITE_REG_CTRL, 1'b1, 32'h1);
    tick(6);
    chk("held before trigger", 32'h18, {24'h0, snk_cnt});
    sync_i <= 8'h02;
    repeat (4) @(posedge clk_i);
    sync_i <= 8'h00;
    tick(4);
    // a trigger in mid burst must be ignored
    sync_i <= 8'h02;
    repeat (4) @(posedge clk_i);
    sync_i <= 8'h00;
    tick(8);
    chk("one burst per trigger", 32'h1c, {24'h0, snk_cnt});
    chk("waits for next trigger", 32'h1, {31'h0, running});
    sync_i <= 8'h02;
    repeat (4) @(posedge clk_i);
    sync_i <= 8'h00;
    tick(10);
    chk("second burst", 32'h20, {24'h0, snk_cnt});
    wb(DITE_REG_CTRL, 1'b1, 32'h2);
    wb(DITE_REG_CFG, 1'b1, 32'h42);
    wb(DITE_REG_LINES, 1'b1, 32'ha9);
    wb(DITE_REG_STATIC, 1'b1, 32'h1);
    wb(DITE_REG_PFI, 1'b1, 32'h9);
    repeat (2) @(posedge clk_i);
    chk("line out enable", 32'h1, {28'h0, lines_oe});
    chk("line out value", 32'h1, {31'h0, lines_o[0]});
    chk("pfi routed out", 32'h3, {16'h0, pfi_oe});
    chk("strobe pin idle high", 32'h1, {31'h0, pfi_o[0]});
    wb(DITE_REG_CTRL, 1'b1, 32'h1);
    n = 0;
    repeat (8) begin
      @(negedge clk_i);
      n += (pfi_o[1] === 1'b1);
    end
    chk("start pulse width", 32'h1, n);
    tally_and_finish();
  end
endmodule

bind dite_engine dite_engine_chk i_chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .dma_data_o(dma_data_o),
  .dma_valid_o(dma_valid_o), .dma_ready_i(dma_ready_i),
  .running_o(running_o),
  .programmable_function_pin_oe_o(programmable_function_pin_oe_o));
